// >>> logic/iad_pkg.sv
// Package with address map, switch layout and reset values for the I/O address decoder
package iad_pkg;
	localparam int IAD_ADDR_W = 16;
	localparam int IAD_DATA_W = 8;
	localparam int IAD_WIN_BYTES = 8;
	localparam int IAD_OFS_W = 3;
	localparam int IAD_HI_MSB = 15;
	localparam int IAD_HI_LSB = 8;
	localparam int IAD_LO_MSB = 7;
	localparam int IAD_LO_LSB = 3;
	localparam int IAD_LO_SW_W = 6;
	localparam int IAD_LO_SW_UNUSED = 5;
	localparam logic [7:0] IAD_HI_SW_DEFAULT = 8'h03;
	localparam logic [5:0] IAD_LO_SW_DEFAULT = 6'h00;
	localparam logic [2:0] IAD_OFS_CHA_DATA = 3'h0;
	localparam logic [2:0] IAD_OFS_CHA_CTRL = 3'h1;
	localparam logic [2:0] IAD_OFS_CHB_DATA = 3'h2;
	localparam logic [2:0] IAD_OFS_CHB_CTRL = 3'h3;
	localparam logic [2:0] IAD_OFS_LINE_SIG = 3'h4;
	localparam logic [2:0] IAD_OFS_BOARD_SETUP = 3'h5;
	localparam logic [2:0] IAD_OFS_RSVD_SIX = 3'h6;
	localparam logic [2:0] IAD_OFS_RSVD_SEVEN = 3'h7;
	localparam logic [7:0] IAD_LINE_SIG_RESET = 8'h00;
	localparam logic [7:0] IAD_BOARD_SETUP_RESET = 8'h00;
	localparam logic [7:0] IAD_RSVD_READ = 8'hFF;
	typedef enum logic [1:0] {IAD_SEL_NONE, IAD_SEL_SCC, IAD_SEL_LOCAL, IAD_SEL_RSVD} iad_sel_t;
endpackage

// >>> logic/iad_match.sv
// Base address comparator against the two switch banks
`timescale 1ns/100ps
module iad_match #(
	parameter int ADDR_W = 16
) (
	// Host address
	input wire logic [ADDR_W-1:0] addr,
	// Switch banks
	input wire logic [7:0] high_address_switch_bank,
	input wire logic [5:0] low_address_switch_bank,
	// Result
	output logic hit
);
	import iad_pkg::*;
	logic [4:0] lo_used;
	initial begin
		if (ADDR_W != IAD_ADDR_W) $error("iad_match: only a 16-bit address is served");
	end
	// Sixth position dropped from the compare
	assign lo_used = low_address_switch_bank[IAD_LO_SW_UNUSED-1:0];
	assign hit = (addr[IAD_HI_MSB:IAD_HI_LSB] == high_address_switch_bank)
		&& (addr[IAD_LO_MSB:IAD_LO_LSB] == lo_used);
endmodule

// >>> logic/iad_decoder.sv
// I/O address decoder of the serial adapter card, with onboard registers
// Overview of operation
// - Claim eight contiguous byte addresses from base; low three bits pick location.
// - Address bits 15..8 must equal the high switch bank.
// - Address bits 7..3 must equal the low switch bank; both banks must match.
// - Sixth low switch position takes no part in matching.
// - Base may sit anywhere in 16-bit I/O space, eight-byte aligned.
// - Offsets zero to three pass reads and writes to the serial controller.
// - Offset zero is channel A data, offset one channel A control.
// - Offset two is channel B data, offset three channel B control.
// - Offset four is line signal register, five board setup register.
// - Offsets six and seven reserved: writes ignored, reads return hex FF.
// - Factory base address is hex 300, window 300 to 307.
`timescale 1ns/100ps
module iad_decoder
	import iad_pkg::*;
#(
	parameter int ADDR_W = iad_pkg::IAD_ADDR_W,
	parameter int DATA_W = iad_pkg::IAD_DATA_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Host I/O bus
	input wire logic [ADDR_W-1:0] host_addr,
	input wire logic host_ior_n,
	input wire logic host_iow_n,
	input wire logic [DATA_W-1:0] host_data_in,
	output logic [DATA_W-1:0] host_data_out,
	output logic host_data_oe,
	// Address switches
	input wire logic [7:0] high_address_switch_bank,
	input wire logic [5:0] low_address_switch_bank,
	// Serial controller port
	output logic scc_cs_n,
	output logic scc_rd_n,
	output logic scc_wr_n,
	output logic scc_chan_b,
	output logic scc_ctrl_sel,
	output logic [DATA_W-1:0] scc_wdata,
	input wire logic [DATA_W-1:0] scc_rdata,
	// Onboard register contents
	output logic [DATA_W-1:0] line_signal_q,
	output logic [DATA_W-1:0] board_setup_q
);
	import iad_pkg::*;

	logic hit;
	logic [IAD_OFS_W-1:0] ofs;
	logic rd_act;
	logic wr_act;
	logic [DATA_W-1:0] rdata_d;
	iad_sel_t sel;

	initial begin
		if (ADDR_W != IAD_ADDR_W || DATA_W != IAD_DATA_W) $error("iad_decoder: 16-bit address, 8-bit data only");
	end

	function automatic iad_sel_t region(input logic [2:0] o);
		case (o)
			IAD_OFS_CHA_DATA, IAD_OFS_CHA_CTRL, IAD_OFS_CHB_DATA, IAD_OFS_CHB_CTRL: region = IAD_SEL_SCC;
			IAD_OFS_LINE_SIG, IAD_OFS_BOARD_SETUP: region = IAD_SEL_LOCAL;
			IAD_OFS_RSVD_SIX, IAD_OFS_RSVD_SEVEN: region = IAD_SEL_RSVD;
			default: region = IAD_SEL_NONE;
		endcase
	endfunction

	iad_match #(
		.ADDR_W(ADDR_W)
	) u_match (
		.addr(host_addr),
		.high_address_switch_bank(high_address_switch_bank),
		.low_address_switch_bank(low_address_switch_bank),
		.hit(hit)
	);

	// Window offset and strobes
	assign ofs = host_addr[IAD_OFS_W-1:0];
	assign sel = hit ? region(ofs) : IAD_SEL_NONE;
	assign rd_act = hit && !host_ior_n && host_iow_n;
	assign wr_act = hit && !host_iow_n && host_ior_n;

	// Read data selection
	always_comb begin
		rdata_d = IAD_RSVD_READ;
		case (sel)
			IAD_SEL_SCC: rdata_d = scc_rdata;
			IAD_SEL_LOCAL: rdata_d = (ofs == IAD_OFS_LINE_SIG) ? line_signal_q : board_setup_q;
			IAD_SEL_RSVD: rdata_d = IAD_RSVD_READ;
			default: rdata_d = IAD_RSVD_READ;
		endcase
	end

	// Host data bus drive
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			host_data_oe <= 1'b0;
			host_data_out <= '0;
		end else begin
			host_data_oe <= rd_act;
			host_data_out <= rd_act ? rdata_d : '0;
		end
	end

	// Serial controller pass-through
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			scc_cs_n <= 1'b1;
			scc_rd_n <= 1'b1;
			scc_wr_n <= 1'b1;
			scc_chan_b <= 1'b0;
			scc_ctrl_sel <= 1'b0;
			scc_wdata <= '0;
		end else begin
			scc_cs_n <= !(sel == IAD_SEL_SCC && (rd_act || wr_act));
			scc_rd_n <= !(sel == IAD_SEL_SCC && rd_act);
			scc_wr_n <= !(sel == IAD_SEL_SCC && wr_act);
			scc_chan_b <= ofs[1];
			scc_ctrl_sel <= ofs[0];
			scc_wdata <= host_data_in;
		end
	end

	// Line signal register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			line_signal_q <= IAD_LINE_SIG_RESET;
		end else if (wr_act && ofs == IAD_OFS_LINE_SIG) begin
			line_signal_q <= host_data_in;
		end
	end

	// Board setup register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			board_setup_q <= IAD_BOARD_SETUP_RESET;
		end else if (wr_act && ofs == IAD_OFS_BOARD_SETUP) begin
			board_setup_q <= host_data_in;
		end
	end

	// Helper: previous-cycle decode
	logic [ADDR_W-1:0] addr_p;
	logic wr_p;
	logic rd_p;
	logic [DATA_W-1:0] din_p;
	always_ff @(posedge clk_sys) begin
		addr_p <= host_addr;
		wr_p <= wr_act;
		rd_p <= rd_act;
		din_p <= host_data_in;
	end

	a_oe_read_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
		host_data_oe |-> $past(rd_act)) else $error("data bus driven without decoded read");
	a_oe_follows_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
		rd_act |=> host_data_oe) else $error("decoded read not answered");
	a_miss_hi_bank: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(host_addr[15:8] != high_address_switch_bank) |-> !hit) else $error("high bank mismatch claimed");
	a_miss_lo_bank: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(host_addr[7:3] != low_address_switch_bank[4:0]) |-> !hit) else $error("low bank mismatch claimed");
	a_sixth_ignored: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(host_addr[15:8] == high_address_switch_bank && host_addr[7:3] == low_address_switch_bank[4:0])
		|-> hit) else $error("matching base not claimed");
	a_scc_window: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!scc_cs_n |-> ($past(hit) && $past(host_addr[2]) == 1'b0)) else $error("controller selected outside 0..3");
	a_scc_chan_map: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!scc_cs_n |-> (scc_chan_b == addr_p[1] && scc_ctrl_sel == addr_p[0])) else $error("channel map wrong");
	a_line_sig_wr: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_act && ofs == IAD_OFS_LINE_SIG) |=> line_signal_q == din_p) else $error("line signal write lost");
	a_rsvd_no_effect: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_p && addr_p[2:1] == 2'b11) |-> ($stable(line_signal_q) && $stable(board_setup_q) && scc_cs_n))
		else $error("reserved write had effect");
	a_rd_scc_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(rd_act && sel == IAD_SEL_SCC) |=> (host_data_out == $past(scc_rdata) && !scc_rd_n))
		else $error("controller read not passed");

	// Further guards on the decode and the bus drive
	a_setup_wr: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_act && ofs == IAD_OFS_BOARD_SETUP) |=> board_setup_q == din_p)
		else $error("board setup write lost");

	a_scc_rd_sel: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!scc_rd_n |-> !scc_cs_n)
		else $error("controller read strobe without select");

	a_scc_wr_pass: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_act && sel == IAD_SEL_SCC) |=> (!scc_wr_n && scc_wdata == din_p))
		else $error("controller write not passed");

	a_rsvd_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(rd_act && sel == IAD_SEL_RSVD) |=> host_data_out == IAD_RSVD_READ)
		else $error("reserved read value wrong");

	a_line_sig_rd: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(rd_act && ofs == IAD_OFS_LINE_SIG) |=> host_data_out == $past(line_signal_q))
		else $error("line signal read wrong");

	a_setup_rd: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(rd_act && ofs == IAD_OFS_BOARD_SETUP) |=> host_data_out == $past(board_setup_q))
		else $error("board setup read wrong");

	a_idle_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!host_data_oe |-> host_data_out == '0)
		else $error("data shown while released");

	a_no_claim: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!hit |=> (scc_cs_n && !host_data_oe))
		else $error("unclaimed access answered");

	a_both_strobes: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!host_ior_n && !host_iow_n) |=> (scc_cs_n && !host_data_oe))
		else $error("double strobe answered");

	a_local_no_scc: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(sel == IAD_SEL_LOCAL && (rd_act || wr_act)) |=> scc_cs_n)
		else $error("controller selected for onboard register");

	a_wr_no_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wr_act |=> !host_data_oe)
		else $error("data bus driven on write");

	a_factory_base: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(high_address_switch_bank == IAD_HI_SW_DEFAULT && low_address_switch_bank[4:0] == IAD_LO_SW_DEFAULT[4:0]
		&& host_addr[15:3] == 13'h0060) |-> hit) else $error("factory base not claimed");
endmodule

// >>> tb/iad_scc_model.sv
// Serial controller stand-in behind the decoder
`timescale 1ns/100ps
module iad_scc_model (
	// Clock
	input wire logic clk_sys,
	// Controller port
	input wire logic scc_cs_n,
	input wire logic scc_wr_n,
	input wire logic scc_chan_b,
	input wire logic scc_ctrl_sel,
	input wire logic [7:0] scc_wdata,
	output logic [7:0] scc_rdata
);
	logic [7:0] mem [4];
	logic [7:0] junk_q = 8'h5A;
	always @(posedge clk_sys) begin
		junk_q <= junk_q + 8'h3B;
		if (!scc_cs_n && !scc_wr_n) mem[{scc_chan_b, scc_ctrl_sel}] <= scc_wdata;
	end
	// Released port shows junk
	assign scc_rdata = scc_cs_n ? junk_q : mem[{scc_chan_b, scc_ctrl_sel}];
endmodule

// >>> tb/iad_decoder_test.sv
// Self-checking bench for the I/O address decoder
`timescale 1ns/100ps
module iad_decoder_test;
	import iad_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [15:0] host_addr = 16'h0000;
	logic host_ior_n = 1'b1;
	logic host_iow_n = 1'b1;
	logic [7:0] host_data_in = 8'h00;
	logic [7:0] hi_sw = IAD_HI_SW_DEFAULT;
	logic [5:0] lo_sw = IAD_LO_SW_DEFAULT;
	logic [7:0] data_out, scc_wdata, scc_rdata, line_q, setup_q, last_rd, exp;
	logic oe, oe_p, cs_n, chan_b, ctrl_sel, wr_n, rd_n;
	logic cur_rd = 1'b0;
	logic [7:0] exp_q [$];
	logic [7:0] wv [8];
	logic [15:0] base;
	int n_errors = 0;
	int n_compared = 0;
	int seed = 60027;
	always #2.5 clk_sys = ~clk_sys;
	iad_decoder dut (.clk_sys, .reset_n, .host_addr, .host_ior_n, .host_iow_n, .host_data_in,
		.host_data_out(data_out), .host_data_oe(oe), .high_address_switch_bank(hi_sw),
		.low_address_switch_bank(lo_sw), .scc_cs_n(cs_n), .scc_rd_n(rd_n), .scc_wr_n(wr_n),
		.scc_chan_b(chan_b), .scc_ctrl_sel(ctrl_sel), .scc_wdata, .scc_rdata,
		.line_signal_q(line_q), .board_setup_q(setup_q));
	iad_scc_model scc (.clk_sys, .scc_cs_n(cs_n), .scc_wr_n(wr_n), .scc_chan_b(chan_b),
		.scc_ctrl_sel(ctrl_sel), .scc_wdata, .scc_rdata);
	task automatic check(string what, logic [7:0] seen, logic [7:0] want);
		n_compared++;
		if (seen !== want) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic print_verdict();
		$display("Compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// One strobe held two cycles
	task automatic acc(logic [15:0] a, logic wr, logic [7:0] d);
		@(negedge clk_sys);
		host_addr = a;
		host_data_in = d;
		cur_rd = !wr;
		host_ior_n = wr;
		host_iow_n = !wr;
		repeat (2) @(negedge clk_sys);
		host_ior_n = 1'b1;
		host_iow_n = 1'b1;
		@(negedge clk_sys);
	endtask
	// Output watcher
	always @(negedge clk_sys) begin
		if (cs_n === 1'b0) check("slot", {6'h00, chan_b, ctrl_sel}, {6'h00, host_addr[1:0]});
		if (cs_n === 1'b0) check("read strobe", {7'h00, rd_n}, {7'h00, !cur_rd});
		if (oe === 1'b1) last_rd = data_out;
		else check("idle data", data_out, 8'h00);
		if (oe_p === 1'b1 && oe !== 1'b1) begin
			exp = exp_q.size() ? exp_q.pop_front() : ~last_rd;
			check("read data", last_rd, exp);
		end
		oe_p = oe;
	end
	initial begin
		#20000;
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (20) @(negedge clk_sys);
		reset_n = 1'b1;
		check("line reset", line_q, IAD_LINE_SIG_RESET);
		check("setup reset", setup_q, IAD_BOARD_SETUP_RESET);
		for (int k = 0; k < 4; k++) begin
			if (k == 1) begin
				hi_sw = 8'hFF;
				lo_sw = 6'h1F;
			end
			if (k > 1) begin
				hi_sw = 8'($random(seed));
				lo_sw = 6'($random(seed));
			end
			base = {hi_sw, lo_sw[4:0], 3'h0};
			if (k == 0) check("factory base", base[15:8], 8'h03);
			for (int i = 0; i < 8; i++) begin
				wv[i] = 8'($random(seed));
				acc(base + 16'(i), 1'b1, wv[i]);
			end
			check("line signal", line_q, wv[4]);
			check("board setup", setup_q, wv[5]);
			lo_sw[5] = ~lo_sw[5];
			for (int i = 0; i < 8; i++) begin
				exp_q.push_back(i < 6 ? wv[i] : IAD_RSVD_READ);
				acc(base + 16'(i), 1'b0, 8'h00);
			end
			acc(base ^ 16'h0100, 1'b0, 8'h00);
			acc(base ^ 16'h000C, 1'b1, ~wv[4]);
			check("line kept", line_q, wv[4]);
		end
		check("pending reads", 8'(exp_q.size()), 8'h00);
		print_verdict();
	end
endmodule
